// ==== dv/tb_top.sv ====
// Self-checking bench for the protected-configuration watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic alwaysOnFuse = 0, compatibilityFuse = 0, oscTick = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, chipResetPulse, watchdogRunning;
  int failures = 0, cmp_count = 0, pulses = 0;
  typedef struct {logic aon, cmp; logic [31:0] lvl, ctl;} wdc_row_type;
  // Fuse pair, status level, control reset value
  wdc_row_type rows[4] = '{'{1'h0, 1'h0, 32'h1, 32'h0}, '{1'h0, 1'h1, 32'h0, 32'h0},
    '{1'h1, 1'h0, 32'h2, 32'h8}, '{1'h1, 1'h1, 32'h2, 32'h8}};
  // Small base count keeps expiry runs short
  wdc_watchdog #(.BASE_CYCLES(4), .ADDR_W(8)) dut (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .alwaysOnFuse, .compatibilityFuse,
    .oscTick, .chipResetPulse, .watchdogRunning);
  initial forever #25 clock = ~clock;
  always @(posedge clock) if (chipResetPulse === 1'h1) pulses <= pulses + 1;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // Only the watchdog process ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic boot(input logic a, c);
    alwaysOnFuse <= a;
    compatibilityFuse <= c;
    rst <= 1'h1;
    repeat (16) @(posedge clock);
    rst <= 1'h0;
  endtask
  // Oscillator edge every six clocks, well above the synchroniser's need
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clock);
      oscTick <= 1'h1;
      repeat (3) @(posedge clock);
      oscTick <= 1'h0;
      repeat (2) @(posedge clock);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      boot(rows[i].aon, rows[i].cmp);
      apb(1'h0, 8'h04, 32'h0);
      chk(rd, rows[i].lvl);
      apb(1'h0, 8'h00, 32'h0);
      chk(rd, rows[i].ctl);
      chk({31'h0, watchdogRunning}, rows[i].ctl >> 3);
    end
    $display("fuse table done");
    apb(1'h0, 8'h10, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'h1, 8'h00, 32'h18);
    apb(1'h1, 8'h00, 32'h03);
    apb(1'h1, 8'h00, 32'h05);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0b);
    $display("level 2 done");
    boot(1'h0, 1'h0);
    apb(1'h1, 8'h00, 32'h0b);
    apb(1'h1, 8'h00, 32'h00);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h08);
    apb(1'h1, 8'h00, 32'h18);
    repeat (6) @(posedge clock);
    apb(1'h1, 8'h00, 32'h02);
    // Let the late write's edge pass before looking at its effect
    @(posedge clock);
    chk({31'h0, watchdogRunning}, 32'h1);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h08);
    apb(1'h1, 8'h00, 32'h18);
    apb(1'h1, 8'h00, 32'h02);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h02);
    $display("level 1 done");
    boot(1'h0, 1'h1);
    apb(1'h1, 8'h00, 32'h09);
    apb(1'h1, 8'h00, 32'h0a);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0a);
    tk(15);
    chk(pulses, 32'h0);
    tk(1);
    chk(pulses, 32'h1);
    tk(10);
    apb(1'h1, 8'h08, 32'h1);
    apb(1'h0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    tk(15);
    chk(pulses, 32'h1);
    apb(1'h1, 8'h00, 32'h18);
    apb(1'h1, 8'h00, 32'h00);
    tk(20);
    chk({watchdogRunning, pulses[30:0]}, 32'h1);
    $display("expiry done");
    report_and_stop;
  end
  initial begin
    #1000000;
    failures++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire

// ==== dv/wdc_watchdog_asserts.sv ====
// Port-level assertions for the protected-configuration watchdog
`timescale 1ns/1ps
`default_nettype none
module wdc_watchdog_asserts #(
  parameter int unsigned BASE_CYCLES = 16384,
  parameter int ADDR_W = 8
) (
  // System
  input wire logic clock, rst,
  // APB slave
  input wire logic psel, penable, pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr,
  // Fuses, oscillator, outputs
  input wire logic alwaysOnFuse, compatibilityFuse, oscTick,
  input wire logic chipResetPulse, watchdogRunning
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_lvl2_on: assert property (alwaysOnFuse |-> watchdogRunning)
    else $error("level 2 watchdog not running");
  chk_pulse_one: assert property (chipResetPulse |=> !chipResetPulse)
    else $error("chip reset pulse longer than one cycle");
  chk_pulse_run: assert property (chipResetPulse |-> $past(watchdogRunning))
    else $error("chip reset pulse while disabled");
  chk_start_off: assert property ($fell(rst) && !alwaysOnFuse |-> !watchdogRunning)
    else $error("watchdog running after reset");
  // Enabling needs a control write carrying the enable bit
  chk_en_write: assert property ($rose(watchdogRunning) && !alwaysOnFuse |->
    $past(psel && penable && pwrite && paddr == 'h0 && pwdata[3]))
    else $error("watchdog enabled without a write");
  chk_dis_write: assert property ($fell(watchdogRunning) |->
    $past(psel && penable && pwrite && paddr == 'h0 && !pwdata[3] && !pwdata[4]))
    else $error("watchdog disabled without a write");
  chk_ready_access: assert property (pready == (psel && penable))
    else $error("pready outside access cycle");
  chk_addr_error: assert property (psel && penable |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("pslverr wrong for address");
endmodule // wdc_watchdog_asserts
bind wdc_watchdog wdc_watchdog_asserts #(.BASE_CYCLES(BASE_CYCLES), .ADDR_W(ADDR_W)) u_chk (
  .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .alwaysOnFuse, .compatibilityFuse, .oscTick, .chipResetPulse, .watchdogRunning);
`default_nettype wire

// ==== hdl/wdc_cnt_if.sv ====
// Signals between the configuration logic and the timeout counter
`timescale 1ns/1ps
`default_nettype none
interface wdc_cnt_if;
  logic run;
  logic restart;
  logic [wdc_pkg::WDC_PS_W-1:0] prescale;
  logic expire;
  logic [wdc_pkg::WDC_CNT_W-1:0] count;
  modport ctrl (output run, output restart, output prescale, input expire, input count);
  modport cnt (input run, input restart, input prescale, output expire, output count);
endinterface
`default_nettype wire

// ==== hdl/wdc_counter.sv ====
// Timeout counter running on synchronised watchdog oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module wdc_counter #(
  parameter int unsigned BASE_CYCLES = wdc_pkg::WDC_BASE_CYCLES
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // Watchdog oscillator
  input wire logic oscTick,
  // Control side
  wdc_cnt_if.cnt cnt
);
  logic oscSync1_ff, oscSync2_ff, oscSync3_ff;
  logic nxt_oscSync1, nxt_oscSync2, nxt_oscSync3;
  logic [wdc_pkg::WDC_CNT_W-1:0] count_ff, nxt_count;
  logic expire_ff, nxt_expire;
  logic [wdc_pkg::WDC_CNT_W-1:0] limit;
  logic tickEdge;

  // Only the second and third stages are looked at; the first may be metastable
  always_comb begin
    nxt_oscSync1 = oscTick;
    nxt_oscSync2 = oscSync1_ff;
    nxt_oscSync3 = oscSync2_ff;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oscSync1_ff <= 1'b0;
      oscSync2_ff <= 1'b0;
      oscSync3_ff <= 1'b0;
    end else begin
      oscSync1_ff <= nxt_oscSync1; // [R16]
      oscSync2_ff <= nxt_oscSync2; // [R16]
      oscSync3_ff <= nxt_oscSync3;
    end
  end

  always_comb begin
    tickEdge = oscSync2_ff & ~oscSync3_ff; // [R16]
    limit = wdc_pkg::WDC_CNT_W'((BASE_CYCLES << cnt.prescale) - 1); // [R1]
    nxt_count = count_ff;
    nxt_expire = 1'b0;
    // A lowered prescale below the running count expires on the next tick
    if (!cnt.run || cnt.restart) begin
      nxt_count = '0; // [R14]
    end else if (tickEdge) begin
      if (count_ff >= limit) begin
        nxt_count = '0;
        nxt_expire = 1'b1; // [R13]
      end else begin
        nxt_count = count_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff <= '0; // [R14]
      expire_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      expire_ff <= nxt_expire;
    end
  end

  assign cnt.count = count_ff;
  assign cnt.expire = expire_ff;
endmodule // wdc_counter
`default_nettype wire

// ==== hdl/wdc_pkg.sv ====
// Constants and types shared by the protected-configuration watchdog
// Operation
// [R1] Timeout is 16K to 2048K oscillator cycles, doubling with each prescale code.
// [R2] Level 0 starts disabled; a plain write of one enables the watchdog.
// [R3] Level 0 accepts any new prescale value at any time.
// [R4] Level 1 starts disabled; a plain write of one enables the watchdog.
// [R5] Level 1 changes prescale or disables only through the timed sequence.
// [R6] Software opens the sequence writing change-enable and enable both one; the code opens it on change-enable alone, whatever enable holds.
// [R7] Within four cycles a write with change-enable clear is applied.
// [R8] Level 2 keeps the watchdog enabled; enable always reads one.
// [R9] Level 2 software also opens the sequence with both bits one; the code opens it on change-enable alone, whatever enable holds.
// [R10] Level 2 timed write updates prescale only; enable value is ignored.
// [R11] Change-enable clears itself four cycles after being written one.
// [R12] Safety level comes from the always-on and compatibility fuses.
// [R13] Expiry without restart gives a one-cycle chip reset pulse.
// [R14] Count clears on restart, on disable and on any chip reset.
// [R15] Protected changes outside the open window are ignored.
// [R16] Oscillator ticks and requests cross into the count logic safely.
package wdc_pkg;
  // Register byte offsets
  localparam logic [7:0] WDC_CTRL_OFF = 8'h00;
  localparam logic [7:0] WDC_STATUS_OFF = 8'h04;
  localparam logic [7:0] WDC_RESTART_OFF = 8'h08;
  localparam logic [7:0] WDC_COUNT_OFF = 8'h0c;
  // Control register fields
  localparam int WDC_PS_LSB = 0;
  localparam int WDC_PS_W = 3;
  localparam int WDC_EN_BIT = 3;
  localparam int WDC_CE_BIT = 4;
  localparam logic [WDC_PS_W-1:0] WDC_PS_RST = 3'h0;
  localparam logic WDC_EN_RST = 1'b0;
  // Restart register field
  localparam int WDC_RESTART_BIT = 0;
  // Status register fields
  localparam int WDC_ST_LVL_LSB = 0;
  localparam int WDC_ST_OPEN_BIT = 2;
  localparam int WDC_ST_WCNT_LSB = 3;
  // Timing
  localparam int WDC_CE_CYCLES = 4;
  localparam int WDC_WCNT_W = 3;
  localparam int unsigned WDC_BASE_CYCLES = 16384;
  localparam int WDC_CNT_W = 22;

  typedef enum logic [1:0] {
    WDC_LVL0 = 2'b00,
    WDC_LVL1 = 2'b01,
    WDC_LVL2 = 2'b10
  } wdc_level_type;
endpackage

// ==== hdl/wdc_watchdog.sv ====
// Watchdog with fuse-selected safety level and timed configuration changes, APB slave
`timescale 1ns/1ps
`default_nettype none
module wdc_watchdog #(
  parameter int unsigned BASE_CYCLES = wdc_pkg::WDC_BASE_CYCLES,
  parameter int ADDR_W = 8
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fuses, high when programmed
  input wire logic alwaysOnFuse,
  input wire logic compatibilityFuse,
  // Watchdog oscillator
  input wire logic oscTick,
  // Chip reset request and state
  output logic chipResetPulse,
  output logic watchdogRunning
);
  wdc_cnt_if cntBus ();

  wdc_counter #(
    .BASE_CYCLES(BASE_CYCLES)
  ) uCounter (
    .clock(clock),
    .rst(rst),
    .oscTick(oscTick),
    .cnt(cntBus)
  );

  wdc_pkg::wdc_level_type level;
  logic enable_ff, nxt_enable;
  logic [wdc_pkg::WDC_PS_W-1:0] prescale_ff, nxt_prescale;
  logic ceOpen_ff, nxt_ceOpen;
  logic [wdc_pkg::WDC_WCNT_W-1:0] ceCnt_ff, nxt_ceCnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic effEnable;
  logic accessWr, setupRd;
  logic ctrlWr, restartWr;
  logic wCe, wEn;
  logic [wdc_pkg::WDC_PS_W-1:0] wPs;
  logic mapped;
  logic [7:0] addr8;
  logic [31:0] rdData;

  // Fuses are static straps, so decoding them directly needs no capture
  always_comb begin
    if (alwaysOnFuse) begin
      level = wdc_pkg::WDC_LVL2; // [R12]
    end else if (compatibilityFuse) begin
      level = wdc_pkg::WDC_LVL0; // [R12]
    end else begin
      level = wdc_pkg::WDC_LVL1; // [R12]
    end
  end

  // Level 2 forces the watchdog on whatever the stored bit holds
  assign effEnable = enable_ff | (level == wdc_pkg::WDC_LVL2); // [R8]

  // Bus decode
  always_comb begin
    addr8 = 8'(paddr);
    accessWr = psel & penable & pwrite;
    setupRd = psel & ~penable & ~pwrite;
    mapped = (addr8 == wdc_pkg::WDC_CTRL_OFF) || (addr8 == wdc_pkg::WDC_STATUS_OFF) ||
             (addr8 == wdc_pkg::WDC_RESTART_OFF) || (addr8 == wdc_pkg::WDC_COUNT_OFF);
    if (ADDR_W > 8) begin
      mapped = mapped && ((paddr >> 8) == '0);
    end
    ctrlWr = accessWr && mapped && (addr8 == wdc_pkg::WDC_CTRL_OFF);
    restartWr = accessWr && mapped && (addr8 == wdc_pkg::WDC_RESTART_OFF) &&
                pwdata[wdc_pkg::WDC_RESTART_BIT];
    wCe = pwdata[wdc_pkg::WDC_CE_BIT];
    wEn = pwdata[wdc_pkg::WDC_EN_BIT];
    wPs = pwdata[wdc_pkg::WDC_PS_LSB +: wdc_pkg::WDC_PS_W];
  end

  // Configuration state
  always_comb begin
    nxt_enable = enable_ff;
    nxt_prescale = prescale_ff;
    nxt_ceOpen = ceOpen_ff;
    nxt_ceCnt = ceCnt_ff;
    if (ceCnt_ff != '0) begin
      nxt_ceCnt = ceCnt_ff - 1'b1;
      if (ceCnt_ff == wdc_pkg::WDC_WCNT_W'(1)) begin
        nxt_ceOpen = 1'b0; // [R11]
      end
    end
    if (ctrlWr) begin
      // A new opening write reloads the window, so it wins over the timeout
      if (wCe) begin
        nxt_ceOpen = 1'b1; // [R6] [R9]
        nxt_ceCnt = wdc_pkg::WDC_WCNT_W'(wdc_pkg::WDC_CE_CYCLES); // [R11]
      end
      if (wEn) begin
        nxt_enable = 1'b1; // [R2] [R4]
      end else if (ceOpen_ff && !wCe && level != wdc_pkg::WDC_LVL2) begin
        nxt_enable = 1'b0; // [R5] [R7] [R15]
      end
      unique case (level)
        wdc_pkg::WDC_LVL0: begin
          nxt_prescale = wPs; // [R3]
        end
        wdc_pkg::WDC_LVL1, wdc_pkg::WDC_LVL2: begin
          if (ceOpen_ff && !wCe) begin
            nxt_prescale = wPs; // [R5] [R7] [R10]
          end
        end
        default: begin
          nxt_prescale = prescale_ff; // [R15]
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_ff <= wdc_pkg::WDC_EN_RST; // [R2] [R4]
      prescale_ff <= wdc_pkg::WDC_PS_RST;
      ceOpen_ff <= 1'b0;
      ceCnt_ff <= '0;
    end else begin
      enable_ff <= nxt_enable;
      prescale_ff <= nxt_prescale;
      ceOpen_ff <= nxt_ceOpen;
      ceCnt_ff <= nxt_ceCnt;
    end
  end

  // Counter control
  assign cntBus.run = effEnable; // [R14]
  assign cntBus.restart = restartWr; // [R14]
  assign cntBus.prescale = prescale_ff; // [R1]
  assign chipResetPulse = cntBus.expire; // [R13]
  assign watchdogRunning = effEnable;

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always_comb begin
    rdData = '0;
    if (mapped) begin
      unique case (addr8)
        wdc_pkg::WDC_CTRL_OFF: begin
          rdData[wdc_pkg::WDC_CE_BIT] = ceOpen_ff;
          rdData[wdc_pkg::WDC_EN_BIT] = effEnable; // [R8]
          rdData[wdc_pkg::WDC_PS_LSB +: wdc_pkg::WDC_PS_W] = prescale_ff;
        end
        wdc_pkg::WDC_STATUS_OFF: begin
          rdData[wdc_pkg::WDC_ST_LVL_LSB +: 2] = level;
          rdData[wdc_pkg::WDC_ST_OPEN_BIT] = ceOpen_ff;
          rdData[wdc_pkg::WDC_ST_WCNT_LSB +: wdc_pkg::WDC_WCNT_W] = ceCnt_ff;
        end
        wdc_pkg::WDC_COUNT_OFF: begin
          rdData[wdc_pkg::WDC_CNT_W-1:0] = cntBus.count;
        end
        default: begin
          rdData = '0;
        end
      endcase
    end
    nxt_prdata = setupRd ? rdData : prdata_ff;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_ff <= '0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
endmodule // wdc_watchdog
`default_nettype wire
